// file: ces_pkg.sv
// Constants and types for the CAN error state and interrupt encoder
package ces_pkg;
    // Register byte offsets on the bus
    localparam logic [4:0] ADR_CTRL   = 5'h00;
    localparam logic [4:0] ADR_FLAG   = 5'h04;
    localparam logic [4:0] ADR_EN     = 5'h08;
    localparam logic [4:0] ADR_STAT   = 5'h0C;
    localparam logic [4:0] ADR_COMM   = 5'h10;
    localparam logic [4:0] ADR_CNT    = 5'h14;
    localparam logic [4:0] ADR_PBE    = 5'h18;
    localparam logic [4:0] ADR_FIFO   = 5'h1C;
    // Interrupt flag and enable bit positions
    localparam int F_RX0  = 0;
    localparam int F_RX1  = 1;
    localparam int F_TX0  = 2;
    localparam int F_TX1  = 3;
    localparam int F_TX2  = 4;
    localparam int F_ERR  = 5;
    localparam int F_WAK  = 6;
    localparam int F_MERR = 7;
    // Operating modes
    localparam logic [1:0] MODE_LEGACY = 2'h0;
    localparam logic [1:0] MODE_ENH    = 2'h1;
    localparam logic [1:0] MODE_FIFO   = 2'h2;
    // Error confinement limits
    localparam logic [8:0] LIM_WARN    = 9'h060;
    localparam logic [8:0] LIM_PASSIVE = 9'h080;
    localparam logic [8:0] LIM_BUSOFF  = 9'h100;
    localparam logic [7:0] RECOV_SEQS  = 8'h80;
    localparam logic [8:0] STEP_SMALL  = 9'h001;
    localparam logic [8:0] STEP_BIG    = 9'h008;
    // Legacy interrupt codes
    localparam logic [2:0] IC_NONE = 3'h0;
    localparam logic [2:0] IC_ERR  = 3'h1;
    localparam logic [2:0] IC_TX2  = 3'h2;
    localparam logic [2:0] IC_TX1  = 3'h3;
    localparam logic [2:0] IC_TX0  = 3'h4;
    localparam logic [2:0] IC_RX1  = 3'h5;
    localparam logic [2:0] IC_RX0  = 3'h6;
    localparam logic [2:0] IC_WAK  = 3'h7;
    // Extended interrupt codes
    localparam logic [4:0] EC_NONE = 5'h00;
    localparam logic [4:0] EC_ERR  = 5'h02;
    localparam logic [4:0] EC_TX   = 5'h04;
    localparam logic [4:0] EC_RX   = 5'h08;
    localparam logic [4:0] EC_WAK  = 5'h0E;
    localparam logic [4:0] EC_FIFO = 5'h10;
    typedef enum logic [2:0] {
        ST_ACTIVE  = 3'h1,
        ST_PASSIVE = 3'h2,
        ST_BUSOFF  = 3'h4
    } ces_state_e;
endpackage

// file: ces_error_irq.sv
// CAN error confinement tracking and interrupt code encoder
`timescale 1ns/100ps

// Overview of operation
// - Both counters below 128: error-active
// - Either counter at least 128: error-passive
// - Transmit counter at 256: bus-off, silent
// - 128 recessive sequences recover to active
// - Counters and error mode readable by software
// - Warning flag while either counter >= 96
// - Per-source enables; error flag from many
// - Code shows highest-priority enabled pending source; message error has no code
// - Legacy code encodings fixed, 000 to 111
// - Legacy three-bit code, else five-bit code
// - FIFO mode receive gives code 10000
// - Transmit empty flags, cleared by writing 0
// - Enhanced modes share transmit flag, gated
// - Receive done flags, cleared by writing 0
// - Enhanced modes share one receive flag
// - Message error sets flag, enabled interrupt
// - Bus activity in sleep sets wake-up
// - Error flag on overflow or warning, passive or bus-off flag change
// - Busy buffer match sets its overflow bit
// - Per-side warning flags at 96
// - Per-side passive flags at 128
// - Bus-off flag once transmit counter > 255
module ces_error_irq
    import ces_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [4:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    input  wire logic        REC_INC,
    input  wire logic        REC_INC_BIG,
    input  wire logic        REC_DEC,
    input  wire logic        TEC_INC_BIG,
    input  wire logic        TEC_DEC,
    input  wire logic        RECESSIVE_11,
    input  wire logic [1:0]  RX_DONE,
    input  wire logic [1:0]  RX_OVERRUN,
    input  wire logic [2:0]  TX_EMPTY,
    input  wire logic        MSG_ERROR,
    input  wire logic        BUS_ACTIVITY,
    input  wire logic        SLEEP,
    input  wire logic [4:0]  FIFO_PTR,
    output logic             IRQ,
    output logic             BUS_OFF,
    output logic             WAKE
);

    typedef struct packed {
        logic [1:0]  mode;
        logic [7:0]  flag;
        logic [7:0]  en;
        logic [4:0]  pbe;
        logic [7:0]  rec;
        logic [8:0]  tec;
        ces_state_e  est;
        logic        error_warning_flag;
        logic        rxwarn;
        logic        txwarn;
        logic        rxbp;
        logic        txbp;
        logic        bo;
        logic [1:0]  ovfl;
        logic [7:0]  recov;
        logic        ack;
        logic [31:0] dat;
        logic        irq;
        logic        wake;
    } ces_regs_s;

    ces_regs_s r;
    ces_regs_s next_r;

    // Saturating add and subtract on the counter width
    // A stuck error source pins a counter rather than wrap it
    function automatic logic [8:0] sat_add(input logic [8:0] a,
                                           input logic [8:0] b,
                                           input logic [8:0] top);
        logic [9:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = (s > {1'b0, top}) ? top : s[8:0];
    endfunction

    function automatic logic [8:0] sat_sub(input logic [8:0] a,
                                           input logic [8:0] b);
        sat_sub = (a > b) ? a - b : 9'h000;
    endfunction

    // Receive counter step; the big step wins over the small one
    function automatic logic [7:0] rec_step(input logic [7:0] c,
                                            input logic       inc,
                                            input logic       big,
                                            input logic       dec);
        logic [8:0] w;
        w = {1'b0, c};
        if (big) begin
            w = sat_add(w, STEP_BIG, 9'h0FF);
        end else if (inc) begin
            w = sat_add(w, STEP_SMALL, 9'h0FF);
        end else if (dec) begin
            w = sat_sub(w, STEP_SMALL);
        end
        rec_step = w[7:0];
    endfunction

    // Transmit counter keeps its ninth bit to reach the bus-off limit
    function automatic logic [8:0] tec_step(input logic [8:0] c,
                                            input logic       big,
                                            input logic       dec);
        if (big) begin
            tec_step = sat_add(c, STEP_BIG, 9'h1FF);
        end else if (dec) begin
            tec_step = sat_sub(c, STEP_SMALL);
        end else begin
            tec_step = c;
        end
    endfunction

    // Confinement state from the counters alone
    function automatic ces_state_e conf_state(input logic [8:0] tec,
                                              input logic [7:0] rec);
        if (tec >= LIM_BUSOFF) begin
            conf_state = ST_BUSOFF;
        end else if (tec >= LIM_PASSIVE || {1'b0, rec} >= LIM_PASSIVE) begin
            conf_state = ST_PASSIVE;
        end else begin
            conf_state = ST_ACTIVE;
        end
    endfunction

    // Decode results and per-cycle strobes
    logic [7:0] pend;
    logic [2:0] irq_code;
    logic [4:0] ecode;
    logic [7:0] set_f;
    logic [7:0] clr_f;
    logic       wr;
    logic       take;
    logic       rx_chg;
    logic       tx_chg;
    logic [7:0] comm;
    logic       stat_chg;

    // Pending and enabled sources only; disabled never show
    assign pend = r.flag & r.en;

    // Fixed priority per the legacy truth table, not numeric order
    function automatic logic [2:0] legacy_code(input logic [7:0] p);
        if (p[F_ERR]) begin
            legacy_code = IC_ERR;
        end else if (p[F_TX0]) begin
            legacy_code = IC_TX0;
        end else if (p[F_TX1]) begin
            legacy_code = IC_TX1;
        end else if (p[F_TX2]) begin
            legacy_code = IC_TX2;
        end else if (p[F_RX0]) begin
            legacy_code = IC_RX0;
        end else if (p[F_RX1]) begin
            legacy_code = IC_RX1;
        end else if (p[F_WAK]) begin
            legacy_code = IC_WAK;
        end else begin
            legacy_code = IC_NONE;
        end
    endfunction

    // Shared flags live at the buffer-0 positions
    function automatic logic [4:0] ext_code(input logic [7:0] p,
                                            input logic [1:0] mode);
        if (p[F_ERR]) begin
            ext_code = EC_ERR;
        end else if (p[F_TX0]) begin
            ext_code = EC_TX;
        end else if (p[F_RX0]) begin
            ext_code = (mode == MODE_FIFO) ? EC_FIFO : EC_RX;
        end else if (p[F_WAK]) begin
            ext_code = EC_WAK;
        end else begin
            ext_code = EC_NONE;
        end
    endfunction

    assign irq_code = legacy_code(pend);
    assign ecode = ext_code(pend, r.mode);

    // Communication status bit order as software sees it
    always_comb begin
        comm    = 8'h00;
        comm[0] = r.error_warning_flag;
        comm[1] = r.rxwarn;
        comm[2] = r.txwarn;
        comm[3] = r.rxbp;
        comm[4] = r.txbp;
        comm[5] = r.bo;
        comm[6] = r.ovfl[1];
        comm[7] = r.ovfl[0];
    end

    // Write lands on the edge where ack is high
    assign wr = CYC_I & STB_I & WE_I & r.ack & SEL_I[0];

    // Taken only while ack is low, so a held strobe is not reused
    assign take = CYC_I & STB_I & ~r.ack;

    always_comb begin
        next_r = r;
        set_f  = 8'h00;
        clr_f  = 8'h00;

        // Error counters; bus-off freezes them until recovery
        if (r.est != ST_BUSOFF) begin
            next_r.rec = rec_step(r.rec, REC_INC, REC_INC_BIG,
                                  REC_DEC);
            next_r.tec = tec_step(r.tec, TEC_INC_BIG, TEC_DEC);
        end

        // State follows the registered counters one edge later
        case (r.est)
            ST_ACTIVE, ST_PASSIVE: begin
                // Registered counters, so one edge behind a step
                next_r.est   = conf_state(r.tec, r.rec);
                next_r.recov = 8'h00;
            end
            ST_BUSOFF: begin
                if (RECESSIVE_11) begin
                    // Count reaches 127; this pulse is the 128th
                    if (r.recov == RECOV_SEQS - 8'h01) begin
                        // No software action needed to rejoin
                        next_r.est   = ST_ACTIVE;
                        next_r.rec   = 8'h00;
                        next_r.tec   = 9'h000;
                        next_r.recov = 8'h00;
                    end else begin
                        next_r.recov = r.recov + 8'h01;
                    end
                end
            end
            default: begin
                next_r.est = ST_ACTIVE;
            end
        endcase

        // Status flags from registered counters
        next_r.rxwarn = {1'b0, r.rec} >= LIM_WARN;
        next_r.txwarn = r.tec >= LIM_WARN;
        next_r.error_warning_flag  = next_r.rxwarn | next_r.txwarn;
        next_r.rxbp   = {1'b0, r.rec} >= LIM_PASSIVE;
        next_r.txbp   = r.tec >= LIM_PASSIVE && r.tec < LIM_BUSOFF;
        // Cleared with the state so the pin drops on the rejoin edge
        next_r.bo     = r.tec > 9'h0FF &&
                        next_r.est == ST_BUSOFF;
        rx_chg   = (next_r.rxwarn != r.rxwarn) |
                   (next_r.rxbp != r.rxbp);
        tx_chg   = (next_r.txwarn != r.txwarn) |
                   (next_r.txbp != r.txbp) |
                   (next_r.bo != r.bo);
        stat_chg = rx_chg | tx_chg;

        // Event sources
        if (r.mode == MODE_LEGACY) begin
            set_f[F_RX0] = RX_DONE[0];
            set_f[F_RX1] = RX_DONE[1];
            set_f[F_TX0] = TX_EMPTY[0];
            set_f[F_TX1] = TX_EMPTY[1];
            set_f[F_TX2] = TX_EMPTY[2];
        end else begin
            // One shared flag each, per-buffer enables gate it
            set_f[F_RX0] = |(RX_DONE & r.pbe[4:3]);
            set_f[F_TX0] = |(TX_EMPTY & r.pbe[2:0]);
        end
        set_f[F_ERR]  = (|RX_OVERRUN) | stat_chg;
        // Masked wake leaves no flag behind
        set_f[F_WAK]  = BUS_ACTIVITY & SLEEP & r.en[F_WAK];
        set_f[F_MERR] = MSG_ERROR;

        // Bus access: ack one cycle after the strobe
        next_r.ack = take;
        // Read data stands from the ack edge until the next read
        if (take & ~WE_I) begin
            if (ADR_I == ADR_CTRL) begin
                next_r.dat = {30'h0, r.mode};
            end else if (ADR_I == ADR_FLAG) begin
                next_r.dat = {24'h0, r.flag};
            end else if (ADR_I == ADR_EN) begin
                next_r.dat = {24'h0, r.en};
            end else if (ADR_I == ADR_STAT) begin
                if (r.mode == MODE_LEGACY) begin
                    next_r.dat = {28'h0, irq_code, 1'b0};
                end else begin
                    next_r.dat = {27'h0, ecode};
                end
            end else if (ADR_I == ADR_COMM) begin
                next_r.dat = {24'h0, comm};
            end else if (ADR_I == ADR_CNT) begin
                next_r.dat = {5'h0, r.est, 7'h0, r.tec,
                              r.rec};
            end else if (ADR_I == ADR_PBE) begin
                next_r.dat = {27'h0, r.pbe};
            end else if (ADR_I == ADR_FIFO) begin
                next_r.dat = {27'h0, FIFO_PTR};
            end else begin
                // Unmapped offsets answer and read as zero
                next_r.dat = 32'h0;
            end
        end

        if (wr) begin
            if (ADR_I == ADR_CTRL) begin
                // Undefined mode 3 folds onto FIFO
                next_r.mode = (DAT_I[1:0] == 2'h3) ? MODE_FIFO
                                                   : DAT_I[1:0];
            end else if (ADR_I == ADR_FLAG) begin
                // Writing 0 clears; writing 1 leaves as is
                clr_f = ~DAT_I[7:0];
            end else if (ADR_I == ADR_EN) begin
                next_r.en = DAT_I[7:0];
            end else if (ADR_I == ADR_COMM) begin
                // Overflow bits clear by writing 0, as the flags do
                if (!DAT_I[7]) begin
                    next_r.ovfl[0] = 1'b0;
                end
                if (!DAT_I[6]) begin
                    next_r.ovfl[1] = 1'b0;
                end
            end else if (ADR_I == ADR_PBE) begin
                // Only consulted outside legacy mode
                next_r.pbe = DAT_I[4:0];
            end
        end

        // Set beats clear in the same cycle
        next_r.flag = (r.flag & ~clr_f) | set_f;
        next_r.ovfl = next_r.ovfl | RX_OVERRUN;

        // Next values, so the request rises with its flag
        next_r.irq     = |(next_r.flag & next_r.en);
        next_r.wake    = next_r.flag[F_WAK] & next_r.en[F_WAK];
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            r       <= '0;
            // One-hot state has no all-zero code
            r.est   <= ST_ACTIVE;
        end else begin
            r <= next_r;
        end
    end

    assign DAT_O   = r.dat;
    assign ACK_O   = r.ack;
    assign IRQ     = r.irq;
    // Straight from a flop, never from the state decode
    assign BUS_OFF = r.bo;
    assign WAKE    = r.wake;

endmodule

// file: ces_error_irq_assertions.sv
// Checker for the bus handshake, bus-off and wake-up behaviour
`timescale 1ns/100ps
module ces_error_irq_checker
    import ces_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic [4:0]  ADR_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    input wire logic        TEC_INC_BIG,
    input wire logic        RECESSIVE_11,
    input wire logic        BUS_ACTIVITY,
    input wire logic        SLEEP,
    input wire logic [4:0]  FIFO_PTR,
    input wire logic        BUS_OFF,
    input wire logic        WAKE
);
    // Recovery sequences seen since bus-off began
    logic [7:0] seen;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST)
            seen <= 8'h00;
        else if (!BUS_OFF)
            seen <= 8'h00;
        else if (RECESSIVE_11 && seen != 8'hFF)
            seen <= seen + 8'h01;
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    sequence s_req;
        CYC_I && STB_I && !ACK_O;
    endsequence
    sequence s_fifo_rd;
        s_req ##0 (!WE_I && ADR_I == ADR_FIFO);
    endsequence
    AST_ACK_NEXT:
        assert property (s_req |=> ACK_O)
        else $error("Bus request not answered in one cycle");
    AST_ACK_SINGLE:
        assert property (ACK_O |=> !ACK_O)
        else $error("Acknowledge held beyond one cycle");
    AST_FIFO_READ:
        assert property (s_fifo_rd |=> DAT_O == {27'h0, $past(FIFO_PTR)})
        else $error("FIFO pointer read back wrong");
    AST_BUSOFF_ENTRY:
        assert property ($rose(BUS_OFF) |-> $past(TEC_INC_BIG, 2))
        else $error("Bus-off entered without a transmit error step");
    AST_BUSOFF_HOLD:
        assert property ((BUS_OFF && !RECESSIVE_11) [*3] |=> BUS_OFF)
        else $error("Bus-off left without recovery sequences");
    AST_BUSOFF_RECOVERY:
        assert property ($fell(BUS_OFF) |-> seen >= 8'h7F)
        else $error("Bus-off left too early");
    AST_WAKE_RISE:
        assert property ($rose(WAKE) |-> $past(BUS_ACTIVITY) || $past(ACK_O))
        else $error("Wake request without bus activity");
    AST_WAKE_CLEAR:
        assert property ($fell(WAKE) |-> $past(ACK_O) && $past(WE_I))
        else $error("Wake request dropped without a write");
endmodule
bind ces_error_irq ces_error_irq_checker chk (
    .CLK(CLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .SLEEP(SLEEP),
    .TEC_INC_BIG(TEC_INC_BIG), .RECESSIVE_11(RECESSIVE_11),
    .BUS_ACTIVITY(BUS_ACTIVITY), .FIFO_PTR(FIFO_PTR),
    .BUS_OFF(BUS_OFF), .WAKE(WAKE)
);

// file: ces_bus_node.sv
// Behavioural model of the other nodes sharing the CAN bus
`timescale 1ns/100ps
module ces_bus_node (
    input  wire logic        CLK,
    output logic      [14:0] EV
);
    initial EV = 15'h0000;
    // Slow nodes just hold an event set for a larger n
    task automatic pulse(input logic [14:0] v, input int n);
        EV <= v;
        repeat (n) @(posedge CLK);
        EV <= 15'h0000;
        // Gap lets counters, status and error flags settle
        repeat (3) @(posedge CLK);
    endtask
endmodule

// file: test_can_error_state_and_irq_encoder.sv
// Self-checking bench for the error state and interrupt encoder
`timescale 1ns/100ps
module test_can_error_state_and_irq_encoder
    import ces_pkg::*;
;
    localparam logic [14:0] E_TECB = 15'h0800, E_RECB = 15'h2000,
        E_RECD = 15'h1000, E_RCS = 15'h0200, E_RX0 = 15'h0080,
        E_RX1 = 15'h0100, E_OVR1 = 15'h0040, E_TX0 = 15'h0004,
        E_TX1 = 15'h0008, E_TX2 = 15'h0010, E_MERR = 15'h0002,
        E_ACT = 15'h0001;
    logic        CLK = 1'b0;
    logic        RST = 1'b1;
    logic [2:0]  ctl = 3'h0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] dat = 32'h0;
    logic        sleep = 1'b0;
    logic [4:0]  fifo_ptr = 5'h00;
    logic [31:0] dat_o, q;
    logic        ack, irq, bus_off, wake;
    logic [14:0] ev;
    int          failures = 0, samples_checked = 0, cycles = 0;
    logic [14:0] evs [5] = '{E_RX0, E_RX1, E_TX0, E_TX1, E_TX2};
    logic [2:0]  ics [5] = '{IC_RX0, IC_RX1, IC_TX0, IC_TX1, IC_TX2};
    always #5 CLK = ~CLK;
    ces_bus_node node (.CLK(CLK), .EV(ev));
    ces_error_irq uut (
        .CLK(CLK), .RST(RST), .CYC_I(ctl[2]), .STB_I(ctl[1]),
        .WE_I(ctl[0]), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat),
        .DAT_O(dat_o), .ACK_O(ack), .REC_INC(ev[14]),
        .REC_INC_BIG(ev[13]), .REC_DEC(ev[12]), .TEC_INC_BIG(ev[11]),
        .TEC_DEC(ev[10]), .RECESSIVE_11(ev[9]), .RX_DONE(ev[8:7]),
        .RX_OVERRUN(ev[6:5]), .TX_EMPTY(ev[4:2]), .MSG_ERROR(ev[1]),
        .BUS_ACTIVITY(ev[0]), .SLEEP(sleep), .FIFO_PTR(fifo_ptr),
        .IRQ(irq), .BUS_OFF(bus_off), .WAKE(wake)
    );
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // Classic cycle; the global timeout ends a missing acknowledge
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        {ctl, adr, dat} <= {2'h3, w, a, d};
        @(posedge CLK);
        while (ack !== 1'b1)
            @(posedge CLK);
        q = dat_o;
        ctl <= 3'h0;
        @(posedge CLK);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(q, e);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task finish_test;
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            finish_test;
        end
    end
    initial begin
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        rd(ADR_CNT, 32'h0100_0000);
        wr(ADR_EN, 32'hFF);
        for (int i = 0; i < 5; i++) begin
            node.pulse(evs[i], 1);
            rd(ADR_STAT, {28'h0, ics[i], 1'b0});
            check({31'h0, irq}, 32'h1);
            wr(ADR_FLAG, 32'h0);
            check({31'h0, irq}, 32'h0);
        end
        node.pulse(E_TX2 | E_RX0, 1);
        rd(ADR_STAT, {28'h0, IC_TX2, 1'b0});
        wr(ADR_FLAG, 32'hEF);
        rd(ADR_STAT, {28'h0, IC_RX0, 1'b0});
        wr(ADR_EN, 32'hFE);
        rd(ADR_STAT, 32'h0);
        wr(ADR_FLAG, 32'h0);
        wr(ADR_EN, 32'hFF);
        sleep <= 1'b1;
        node.pulse(E_ACT, 1);
        rd(ADR_STAT, {28'h0, IC_WAK, 1'b0});
        check({31'h0, wake}, 32'h1);
        wr(ADR_FLAG, 32'h0);
        check({31'h0, wake}, 32'h0);
        sleep <= 1'b0;
        node.pulse(E_ACT, 1);
        rd(ADR_FLAG, 32'h0);
        node.pulse(E_MERR, 1);
        rd(ADR_FLAG, 32'h80);
        check({31'h0, irq}, 32'h1);
        wr(ADR_FLAG, 32'h0);
        node.pulse(E_OVR1, 1);
        rd(ADR_COMM, 32'h40);
        rd(ADR_FLAG, 32'h20);
        wr(ADR_COMM, 32'h0);
        rd(ADR_COMM, 32'h0);
        node.pulse(E_RECB, 12);
        rd(ADR_COMM, 32'h03);
        node.pulse(E_RECD, 1);
        rd(ADR_COMM, 32'h00);
        node.pulse(E_TECB, 12);
        rd(ADR_COMM, 32'h05);
        wr(ADR_FLAG, 32'h0);
        node.pulse(E_TECB, 4);
        rd(ADR_COMM, 32'h15);
        rd(ADR_CNT, 32'h0200_805F);
        rd(ADR_STAT, {28'h0, IC_ERR, 1'b0});
        node.pulse(E_TECB, 16);
        rd(ADR_COMM, 32'h25);
        node.pulse(E_RECB, 2);
        rd(ADR_CNT, 32'h0401_005F);
        node.pulse(E_RCS, 127);
        check({31'h0, bus_off}, 32'h1);
        node.pulse(E_RCS, 1);
        rd(ADR_CNT, 32'h0100_0000);
        check({31'h0, bus_off}, 32'h0);
        wr(ADR_FLAG, 32'h0);
        wr(ADR_CTRL, 32'h1);
        wr(ADR_PBE, 32'h09);
        node.pulse(E_TX1, 1);
        rd(ADR_STAT, 32'h0);
        node.pulse(E_TX0, 1);
        rd(ADR_STAT, {27'h0, EC_TX});
        wr(ADR_FLAG, 32'h0);
        node.pulse(E_RX0, 1);
        rd(ADR_STAT, {27'h0, EC_RX});
        wr(ADR_FLAG, 32'h0);
        wr(ADR_CTRL, 32'h2);
        fifo_ptr <= 5'h0B;
        node.pulse(E_RX0, 1);
        rd(ADR_STAT, {27'h0, EC_FIFO});
        rd(ADR_FIFO, 32'h0B);
        node.pulse(15'h4000, 3);
        node.pulse(E_TECB, 1);
        node.pulse(15'h0400, 1);
        rd(ADR_CNT, 32'h0100_0703);
        finish_test;
    end
endmodule
